// ### pst_pkg.sv
package pst_pkg;

   // ==========================================
   // Timing
   localparam int CLK_HZ = 100_000_000;
   localparam int CYC_PER_MS = CLK_HZ / 1000;
   localparam int SEGCHK_MS = 1000;
   localparam int VERSION_MS = 3000;
   localparam int COMPLETE_MS = 1000;
   localparam int OPMSG_MS = 2000;
   localparam int BEEP_MS = 100;
   localparam logic [1:0] SYNC_WAIT = 2'h3;

   // ==========================================
   // Test sequence, LED index = column * 4 + channel
   localparam int NUM_TESTS = 8;
   localparam logic [2:0] LAST_TEST = 3'h7;
   localparam logic [2:0] T_ROM = 3'h0;
   localparam logic [2:0] T_RAM = 3'h1;
   localparam logic [2:0] T_CPU = 3'h2;
   localparam logic [2:0] T_PROBE = 3'h3;
   localparam logic [2:0] T_DISP = 3'h4;
   localparam logic [2:0] T_TRIG = 3'h5;
   localparam logic [2:0] T_EDGE = 3'h6;
   localparam logic [2:0] T_EXTCLK = 3'h7;

   // ==========================================
   // Front-panel settings word
   localparam int SET_TRIGGER_PROGRAM_MODE = 0;
   localparam int SET_CHANNEL_PROGRAM_MODE = 1;
   localparam int SET_DISPLAY = 5;
   localparam int SET_TTL = 9;
   localparam int SET_CHOP = 13;
   localparam int SET_EXT_SYNC = 14;
   localparam int SET_TRIGB_SET = 15;
   localparam int SET_TRIGA = 16;
   localparam logic [7:0] TRIGA_CH1_HI = 8'h01;
   localparam logic [23:0] SETTINGS_INIT = {TRIGA_CH1_HI, 1'b0, 1'b0, 1'b0,
      4'hF, 4'h1, 4'h1, 1'b0};

   // ==========================================
   // Readout and messages
   typedef enum logic [2:0] {
      MSG_NONE = 3'h0,
      MSG_BUSY = 3'h1,
      MSG_COMPLETE = 3'h2,
      MSG_FAIL = 3'h3,
      MSG_OPER = 3'h4
   } pst_msg_t;

   typedef enum logic [2:0] {
      ST_PWRUP = 3'h0,
      ST_SEGCHK = 3'h1,
      ST_START = 3'h3,
      ST_WAIT = 3'h2,
      ST_HALT = 3'h4,
      ST_VERSION = 3'h6,
      ST_COMPLETE = 3'h7,
      ST_IDLE = 3'h5
   } pst_state_t;

   localparam logic [7:0] OPMSG_PUSH_CHAN = 8'h03;
   localparam logic [7:0] OPMSG_PUSH_TRIG = 8'h04;
   localparam logic [3:0] DIGIT_BLANK = 4'hF;
   localparam logic [31:0] SEG_ALL_ON = 32'hFFFFFFFF;

   // BCD failure code for a test and its sub-result
   function automatic logic [7:0] pst_fail_code(input logic [2:0] t, input logic [1:0] s);
      logic [7:0] c;
      c = 8'h00;
      case (t)
         T_ROM: c = {6'h00, s} + 8'h01; // see RULE12
         T_RAM: c = s[0] ? 8'h06 : 8'h05; // see RULE12
         T_CPU: c = (s == 2'h0) ? 8'h07 : ((s == 2'h1) ? 8'h08 : 8'h09); // see RULE12
         T_PROBE: c = 8'h10; // see RULE13
         T_DISP: c = (s == 2'h0) ? 8'h11 : ((s == 2'h1) ? 8'h12 : 8'h13); // see RULE14
         T_TRIG: begin
            case (s)
               2'h0: c = 8'h14; // see RULE15
               2'h1: c = 8'h15;
               2'h2: c = 8'h23;
               default: c = 8'h26;
            endcase
         end
         T_EDGE: c = 8'h34; // see RULE16
         default: c = 8'h70; // see RULE16
      endcase
      return c;
   endfunction

endpackage

// ### pst_timer.sv
`timescale 1ns/100ps
module pst_timer #(
   parameter int W = 32
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic start,
   input wire logic [W-1:0] loadCount,
   output logic done,
   output logic running
);

   typedef struct packed {
      logic [W-1:0] cnt;
      logic done;
      logic running;
   } pst_tmr_t;

   pst_tmr_t r;
   pst_tmr_t n;

   always_comb begin
      n = r;
      n.done = 1'b0;
      if (start) begin
         n.cnt = loadCount;
         n.running = 1'b1;
      end else if (r.running) begin
         if (r.cnt <= W'(1)) begin
            n.running = 1'b0;
            n.done = 1'b1;
         end else begin
            n.cnt = r.cnt - W'(1);
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign done = r.done;
   assign running = r.running;

endmodule

// ### pst_reporter.sv
// Notes on behaviour
// RULE1 - Self-test starts by itself after every power-up reset.
// RULE2 - Readout shows test-busy message while the self-test runs.
// RULE3 - Test-complete message shown briefly at the end, then removed.
// RULE4 - All indicators and a subset of button lamps lit during self-test.
// RULE5 - Threshold display shows all segments and points lit first.
// RULE6 - With no failure, firmware version shown a few seconds before completion.
// RULE7 - Failure reported on readout, threshold display and trigger LEDs together.
// RULE8 - A test's trigger LED glows red on failure, green on pass.
// RULE9 - Any failure halts the sequence and keeps the failure shown.
// RULE10 - Failure shows numeric code on threshold display and readout.
// RULE11 - While halted, any pushbutton press resumes the sequence.
// RULE12 - Program store 01-04 ch1 col1, memory 05-06 ch2, processor 07-09 ch3.
// RULE13 - Probe-offset failure is code 10 on ch4 first column.
// RULE14 - Display failures ch1 second column; trace 11, readout 12 or 13.
// RULE15 - Trigger failures ch2 second column; codes 14, 15, 23, 26.
// RULE16 - Edge detector 34 on ch3 col2; external clock 70 on ch4 col2.
// RULE17 - With backup enabled, saved front-panel settings are restored at power-up.
// RULE18 - With backup link removed, fixed initial settings load at power-up.
// RULE19 - Initial settings: channel mode, ch1 only, TTL, alternate, A=ch1 high.
// RULE20 - Operator message beeps, shows mnemonic on top and code at bottom.
// RULE21 - Channel-only key in trigger mode gives message 3; reverse gives 4.
// RULE22 - Beep-disable link mutes the beep; visual messages remain.
// RULE23 - Host readout must run free-running, ungated, for the readout check.
// RULE24 - Resume clears failure indications and continues with the next test.
`timescale 1ns/100ps
module pst_reporter #(
   parameter int LAMPS = 12,
   parameter logic [LAMPS-1:0] LAMP_MASK = 12'h5A5,
   parameter logic [15:0] FW_VERSION = 16'h0100,
   parameter int unsigned SEGCHK_CYC = pst_pkg::SEGCHK_MS * pst_pkg::CYC_PER_MS,
   parameter int unsigned VERSION_CYC = pst_pkg::VERSION_MS * pst_pkg::CYC_PER_MS,
   parameter int unsigned COMPLETE_CYC = pst_pkg::COMPLETE_MS * pst_pkg::CYC_PER_MS,
   parameter int unsigned OPMSG_CYC = pst_pkg::OPMSG_MS * pst_pkg::CYC_PER_MS,
   parameter int unsigned BEEP_CYC = pst_pkg::BEEP_MS * pst_pkg::CYC_PER_MS
) (
   input wire logic clk_sys,
   input wire logic reset,
   // Test engines, same clock
   input wire logic testDone,
   input wire logic testFail,
   input wire logic [1:0] testFailSub,
   output logic testStart,
   output logic [2:0] testSel,
   // Front panel pins
   input wire logic anyKeyPin,
   input wire logic backupEnableLinkPin,
   input wire logic beepDisableLinkPin,
   // Panel logic, same clock
   input wire logic [23:0] savedSettings,
   input wire logic chanOnlyKey,
   input wire logic trigOnlyKey,
   input wire logic opMsgReq,
   input wire logic [7:0] opMsgCode,
   // Outputs
   output logic [2:0] readoutMsg,
   output logic [7:0] readoutCode,
   output logic [31:0] thresholdSeg,
   output logic indicatorsOn,
   output logic [LAMPS-1:0] buttonLamps,
   output logic [7:0] trigLedRed,
   output logic [7:0] trigLedGreen,
   output logic [23:0] settings,
   output logic settingsLoad,
   output logic settingsFromBackup,
   output logic beep
);

   // ==========================================
   // State
   typedef struct packed {
      pst_pkg::pst_state_t state;
      logic [1:0] syncCnt;
      logic [2:0] testSel;
      logic testStart;
      logic anyFail;
      pst_pkg::pst_msg_t msg;
      logic [7:0] code;
      logic [31:0] seg;
      logic indOn;
      logic [LAMPS-1:0] lamps;
      logic [7:0] red;
      logic [7:0] green;
      logic [23:0] settings;
      logic settingsLoad;
      logic fromBackup;
      logic tLoad;
      logic [31:0] tVal;
      logic bLoad;
      logic beep;
      logic keyS1;
      logic keyS2;
      logic keyS3;
      logic bkS1;
      logic bkS2;
      logic bpS1;
      logic bpS2;
   } pst_regs_t;

   pst_regs_t r;
   pst_regs_t n;

   logic tDone;
   logic bRunning;

   // ==========================================
   // Display helpers
   function automatic logic [7:0] seg7(input logic [3:0] d);
      logic [7:0] s;
      case (d)
         4'h0: s = 8'h3F;
         4'h1: s = 8'h06;
         4'h2: s = 8'h5B;
         4'h3: s = 8'h4F;
         4'h4: s = 8'h66;
         4'h5: s = 8'h6D;
         4'h6: s = 8'h7D;
         4'h7: s = 8'h07;
         4'h8: s = 8'h7F;
         4'h9: s = 8'h6F;
         default: s = 8'h00;
      endcase
      return s;
   endfunction

   function automatic logic [31:0] dispWord(input logic [15:0] bcd);
      return {seg7(bcd[15:12]), seg7(bcd[11:8]), seg7(bcd[7:4]), seg7(bcd[3:0])};
   endfunction

   // ==========================================
   // Timers
   pst_timer #(
      .W(32)
   ) u_phase_tmr (
      .clk_sys(clk_sys),
      .reset(reset),
      .start(r.tLoad),
      .loadCount(r.tVal),
      .done(tDone),
      .running()
   );

   // Own timer for the beep, so a new message restarts it
   pst_timer #(
      .W(32)
   ) u_beep_tmr (
      .clk_sys(clk_sys),
      .reset(reset),
      .start(r.bLoad),
      .loadCount(32'(BEEP_CYC)),
      .done(),
      .running(bRunning)
   );

   // ==========================================
   // Next state
   always_comb begin
      logic keyEdge;
      logic advance;
      logic [7:0] fc;
      keyEdge = r.keyS2 & ~r.keyS3;
      advance = 1'b0;
      fc = pst_pkg::pst_fail_code(r.testSel, testFailSub);
      n = r;
      n.testStart = 1'b0;
      n.settingsLoad = 1'b0;
      n.tLoad = 1'b0;
      n.bLoad = 1'b0;
      n.keyS1 = anyKeyPin;
      n.keyS2 = r.keyS1;
      n.keyS3 = r.keyS2;
      n.bkS1 = backupEnableLinkPin;
      n.bkS2 = r.bkS1;
      n.bpS1 = beepDisableLinkPin;
      n.bpS2 = r.bpS1;
      n.beep = bRunning & ~r.bpS2; // see RULE22

      case (r.state)
         pst_pkg::ST_PWRUP: begin
            n.syncCnt = r.syncCnt + 2'h1;
            if (r.syncCnt == pst_pkg::SYNC_WAIT) begin
               // Links have passed the synchroniser by now
               if (r.bkS2) begin
                  n.settings = savedSettings; // see RULE17
               end else begin
                  n.settings = pst_pkg::SETTINGS_INIT; // see RULE18 see RULE19
               end
               n.fromBackup = r.bkS2;
               n.settingsLoad = 1'b1;
               n.msg = pst_pkg::MSG_BUSY; // see RULE2
               n.indOn = 1'b1; // see RULE4
               n.lamps = LAMP_MASK; // see RULE4
               n.seg = pst_pkg::SEG_ALL_ON; // see RULE5
               n.tLoad = 1'b1;
               n.tVal = 32'(SEGCHK_CYC);
               n.state = pst_pkg::ST_SEGCHK; // see RULE1
            end
         end

         pst_pkg::ST_SEGCHK: begin
            if (tDone) begin
               n.seg = '0;
               n.testSel = pst_pkg::T_ROM;
               n.state = pst_pkg::ST_START;
            end
         end

         pst_pkg::ST_START: begin
            // One start pulse per test
            n.testStart = 1'b1;
            n.state = pst_pkg::ST_WAIT;
         end

         pst_pkg::ST_WAIT: begin
            // Fail qualifiers only trusted alongside testDone
            if (testDone) begin
               if (testFail) begin
                  n.red[r.testSel] = 1'b1; // see RULE7 see RULE8
                  n.anyFail = 1'b1;
                  n.code = fc; // see RULE10
                  n.msg = pst_pkg::MSG_FAIL; // see RULE7
                  n.seg = dispWord({pst_pkg::DIGIT_BLANK, pst_pkg::DIGIT_BLANK, fc}); // see RULE10
                  n.state = pst_pkg::ST_HALT; // see RULE9
               end else begin
                  n.green[r.testSel] = 1'b1; // see RULE8
                  advance = 1'b1;
               end
            end
         end

         pst_pkg::ST_HALT: begin
            // Failure stays up until a key is pressed
            if (keyEdge) begin // see RULE11
               n.red[r.testSel] = 1'b0; // see RULE24
               n.code = 8'h00;
               n.msg = pst_pkg::MSG_BUSY;
               n.seg = '0;
               advance = 1'b1; // see RULE24
            end
         end

         pst_pkg::ST_VERSION: begin
            // Version stays up under the busy message
            if (tDone) begin
               n.seg = '0;
               n.msg = pst_pkg::MSG_COMPLETE; // see RULE3
               n.tLoad = 1'b1;
               n.tVal = 32'(COMPLETE_CYC);
               n.state = pst_pkg::ST_COMPLETE;
            end
         end

         pst_pkg::ST_COMPLETE: begin
            // Lamp test ends together with the complete message
            if (tDone) begin
               n.msg = pst_pkg::MSG_NONE; // see RULE3
               n.indOn = 1'b0;
               n.lamps = '0;
               n.red = '0;
               n.green = '0;
               n.state = pst_pkg::ST_IDLE;
            end
         end

         default: begin
            // Operator messages
            // Only reached when idle, so requests during the self-test are dropped
            if (chanOnlyKey && r.settings[pst_pkg::SET_TRIGGER_PROGRAM_MODE]) begin
               n.code = pst_pkg::OPMSG_PUSH_CHAN; // see RULE21
               n.msg = pst_pkg::MSG_OPER;
               n.bLoad = 1'b1;
               n.tLoad = 1'b1;
               n.tVal = 32'(OPMSG_CYC);
            end else if (trigOnlyKey && !r.settings[pst_pkg::SET_TRIGGER_PROGRAM_MODE]) begin
               n.code = pst_pkg::OPMSG_PUSH_TRIG; // see RULE21
               n.msg = pst_pkg::MSG_OPER;
               n.bLoad = 1'b1;
               n.tLoad = 1'b1;
               n.tVal = 32'(OPMSG_CYC);
            end else if (opMsgReq) begin
               n.code = opMsgCode;
               n.msg = pst_pkg::MSG_OPER; // see RULE20
               n.bLoad = 1'b1; // see RULE20
               n.tLoad = 1'b1;
               n.tVal = 32'(OPMSG_CYC);
            end else if (tDone && r.msg == pst_pkg::MSG_OPER) begin
               n.msg = pst_pkg::MSG_NONE;
               n.code = 8'h00;
            end
         end
      endcase

      // Step to the next test or finish the sequence
      // A run with any failure skips the version display
      if (advance) begin
         if (r.testSel == pst_pkg::LAST_TEST) begin
            if (r.anyFail) begin
               n.msg = pst_pkg::MSG_COMPLETE; // see RULE3
               n.tLoad = 1'b1;
               n.tVal = 32'(COMPLETE_CYC);
               n.state = pst_pkg::ST_COMPLETE;
            end else begin
               n.seg = dispWord(FW_VERSION); // see RULE6
               n.tLoad = 1'b1;
               n.tVal = 32'(VERSION_CYC);
               n.state = pst_pkg::ST_VERSION;
            end
         end else begin
            n.testSel = r.testSel + 3'h1;
            n.state = pst_pkg::ST_START;
         end
      end
   end

   // ==========================================
   // Registers
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   // ==========================================
   // Outputs
   assign testStart = r.testStart;
   assign testSel = r.testSel;
   assign readoutMsg = r.msg;
   assign readoutCode = r.code;
   assign thresholdSeg = r.seg;
   assign indicatorsOn = r.indOn;
   assign buttonLamps = r.lamps;
   assign trigLedRed = r.red;
   assign trigLedGreen = r.green;
   assign settings = r.settings;
   assign settingsLoad = r.settingsLoad;
   assign settingsFromBackup = r.fromBackup;
   assign beep = r.beep;

endmodule

// ### pst_eng_model.sv
`timescale 1ns/100ps
module pst_eng_model (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic testStart,
   input wire logic [2:0] testSel,
   input wire logic [2:0] lat,
   input wire logic [7:0] failMask,
   input wire logic [1:0] failSub,
   output logic testDone,
   output logic testFail,
   output logic [1:0] testFailSub
);
   logic [2:0] cntR;
   // ==========================================
   // Test engine answers lat cycles after each start
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         cntR <= 3'h0;
         testDone <= 1'b0;
         testFail <= 1'b0;
         testFailSub <= 2'h0;
      end else begin
         cntR <= testStart ? lat : ((cntR != 3'h0) ? cntR - 3'h1 : 3'h0);
         // Host readout free-running, so the readout check always answers
         testDone <= (cntR == 3'h1);
         // Qualifiers toggle while not valid
         testFail <= (cntR == 3'h1) ? failMask[testSel] : ~testFail;
         testFailSub <= (cntR == 3'h1) ? failSub : ~testFailSub;
      end
   end
endmodule

// ### pst_reporter_chk.sv
`timescale 1ns/100ps
module pst_reporter_chk (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic testDone,
   input wire logic testFail,
   input wire logic [1:0] testFailSub,
   input wire logic testStart,
   input wire logic [2:0] testSel,
   input wire logic anyKeyPin,
   input wire logic backupEnableLinkPin,
   input wire logic beepDisableLinkPin,
   input wire logic [23:0] savedSettings,
   input wire logic trigOnlyKey,
   input wire logic [2:0] readoutMsg,
   input wire logic [7:0] readoutCode,
   input wire logic [31:0] thresholdSeg,
   input wire logic indicatorsOn,
   input wire logic [7:0] trigLedRed,
   input wire logic [7:0] trigLedGreen,
   input wire logic [23:0] settings,
   input wire logic settingsLoad,
   input wire logic settingsFromBackup,
   input wire logic beep
);
   logic idleR;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   // ==========================================
   // Set once the self-test has completed
   always_ff @(posedge clk_sys) begin
      idleR <= reset ? 1'b0 : (idleR | (readoutMsg == 3'h2));
   end
   sequence s_pass;
      testDone && !testFail && readoutMsg == 3'h1;
   endsequence
   sequence s_fail;
      testDone && testFail && readoutMsg == 3'h1;
   endsequence
   a_busy_at_start: assert property (testStart |-> readoutMsg == 3'h1)
      else $error("test started without busy message");
   a_segment_check: assert property (settingsLoad |-> ##[0:2]
      (thresholdSeg == 32'hFFFFFFFF && indicatorsOn)) else $error("no segment check");
   a_pass_green: assert property (s_pass |=> trigLedGreen[$past(testSel)])
      else $error("passed test not green");
   a_fail_report: assert property (s_fail |=> readoutMsg == 3'h3 &&
      trigLedRed[$past(testSel)]) else $error("failure not reported");
   a_rom_code: assert property (s_fail ##0 testSel == 3'h0 |=>
      readoutCode == {6'h00, $past(testFailSub)} + 8'h01) else $error("wrong store code");
   a_halt_hold: assert property ((!anyKeyPin)[*4] ##0 readoutMsg == 3'h3 |=>
      readoutMsg == 3'h3 && !testStart) else $error("halt not held");
   a_settings_src: assert property (settingsLoad |->
      settingsFromBackup == backupEnableLinkPin && settings ==
      (backupEnableLinkPin ? savedSettings : pst_pkg::SETTINGS_INIT))
      else $error("wrong settings loaded");
   a_opmsg_code: assert property (idleR && readoutMsg != 3'h2 && trigOnlyKey &&
      !settings[0] |=> readoutMsg == 3'h4 && readoutCode == 8'h04)
      else $error("operator message 4 missing");
   a_beep_mute: assert property (beepDisableLinkPin[*4] |-> !beep)
      else $error("beep while muted");
endmodule
bind pst_reporter pst_reporter_chk u_chk (.clk_sys(clk_sys), .reset(reset),
   .testDone(testDone), .testFail(testFail), .testFailSub(testFailSub),
   .testStart(testStart), .testSel(testSel), .anyKeyPin(anyKeyPin),
   .backupEnableLinkPin(backupEnableLinkPin), .beepDisableLinkPin(beepDisableLinkPin),
   .savedSettings(savedSettings), .trigOnlyKey(trigOnlyKey), .readoutMsg(readoutMsg),
   .readoutCode(readoutCode), .thresholdSeg(thresholdSeg), .indicatorsOn(indicatorsOn),
   .trigLedRed(trigLedRed), .trigLedGreen(trigLedGreen), .settings(settings),
   .settingsLoad(settingsLoad), .settingsFromBackup(settingsFromBackup), .beep(beep));

// ### tb_pst_reporter.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin failCount++; \
   $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module tb_pst_reporter;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic anyKeyPin = 1'b0, backupEnableLinkPin = 1'b0, beepDisableLinkPin = 1'b0;
   logic chanOnlyKey = 1'b0, trigOnlyKey = 1'b0, opMsgReq = 1'b0;
   logic [23:0] savedSettings = 24'h000000;
   logic [7:0] opMsgCode = 8'h00, failMask = 8'h00;
   logic [1:0] failSub = 2'h0;
   logic [2:0] lat = 3'h3;
   logic testDone, testFail, testStart, settingsLoad, settingsFromBackup, beep, indicatorsOn;
   logic [1:0] testFailSub;
   logic [2:0] testSel, readoutMsg;
   logic [7:0] readoutCode, trigLedRed, trigLedGreen;
   logic [31:0] thresholdSeg;
   logic [11:0] buttonLamps;
   logic [23:0] settings;
   int failCount = 0;
   int checks = 0;
   // Test, sub-result and expected code
   logic [15:0] tbl [19] = '{16'h0001, 16'h0102, 16'h0203, 16'h0304, 16'h1005, 16'h1106,
      16'h2007, 16'h2108, 16'h2209, 16'h3010, 16'h4011, 16'h4112, 16'h4213, 16'h5014,
      16'h5115, 16'h5223, 16'h5326, 16'h6034, 16'h7070};
   always #5 clk_sys = ~clk_sys;
   pst_reporter #(.LAMP_MASK(12'h3C3), .SEGCHK_CYC(20), .VERSION_CYC(30),
      .COMPLETE_CYC(10), .OPMSG_CYC(15)) uut (.clk_sys(clk_sys),
      .reset(reset), .testDone(testDone), .testFail(testFail), .testFailSub(testFailSub),
      .testStart(testStart), .testSel(testSel), .anyKeyPin(anyKeyPin),
      .backupEnableLinkPin(backupEnableLinkPin), .beepDisableLinkPin(beepDisableLinkPin),
      .savedSettings(savedSettings), .chanOnlyKey(chanOnlyKey), .trigOnlyKey(trigOnlyKey),
      .opMsgReq(opMsgReq), .opMsgCode(opMsgCode), .readoutMsg(readoutMsg),
      .readoutCode(readoutCode), .thresholdSeg(thresholdSeg), .indicatorsOn(indicatorsOn),
      .buttonLamps(buttonLamps), .trigLedRed(trigLedRed), .trigLedGreen(trigLedGreen),
      .settings(settings), .settingsLoad(settingsLoad),
      .settingsFromBackup(settingsFromBackup), .beep(beep));
   pst_eng_model eng (.clk_sys(clk_sys), .reset(reset), .testStart(testStart),
      .testSel(testSel), .lat(lat), .failMask(failMask), .failSub(failSub),
      .testDone(testDone), .testFail(testFail), .testFailSub(testFailSub));
   // ==========================================
   // Helpers
   task automatic final_report();
      if (failCount == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic waitMsg(input logic [2:0] m, input int lim);
      for (int i = 0; i < lim && readoutMsg !== m; i++) tick(1);
      if (readoutMsg !== m) begin
         failCount++;
         $display("unexpected readoutMsg exp %0h got %0h", m, readoutMsg);
         final_report();
      end
   endtask
   task automatic boot(input logic bk, input logic bo, input logic [7:0] fm,
         input logic [1:0] fs);
      reset = 1'b1;
      backupEnableLinkPin = bk;
      beepDisableLinkPin = bo;
      failMask = fm;
      failSub = fs;
      tick(5);
      reset = 1'b0;
      for (int i = 0; i < 12 && settingsLoad !== 1'b1; i++) tick(1);
      `CHK("settingsLoad", 1'b1, settingsLoad)
      if (settingsLoad !== 1'b1) final_report();
      `CHK("settings", bk ? savedSettings : pst_pkg::SETTINGS_INIT, settings)
      `CHK("settingsFromBackup", bk, settingsFromBackup)
      tick(2);
      `CHK("thresholdSeg", pst_pkg::SEG_ALL_ON, thresholdSeg)
      `CHK("buttonLamps", 12'h3C3, buttonLamps)
      `CHK("readoutMsg", 3'h1, readoutMsg)
   endtask
   task automatic pulse(input int k);
      chanOnlyKey = (k == 0);
      trigOnlyKey = (k == 1);
      opMsgReq = (k == 2);
      tick(1);
      chanOnlyKey = 1'b0;
      trigOnlyKey = 1'b0;
      opMsgReq = 1'b0;
   endtask
   // ==========================================
   // Scenarios
   task automatic sc_pass_idle();
      boot(1'b0, 1'b0, 8'h00, 2'h0);
      for (int i = 0; i < 400 && trigLedGreen !== 8'hFF; i++) tick(1);
      `CHK("trigLedGreen", 8'hFF, trigLedGreen)
      if (trigLedGreen !== 8'hFF) final_report();
      // Version 01.00 on the four digits
      `CHK("thresholdSeg", 32'h3F063F3F, thresholdSeg)
      `CHK("readoutMsg", 3'h1, readoutMsg)
      waitMsg(3'h2, 400);
      `CHK("trigLedGreen", 8'hFF, trigLedGreen)
      waitMsg(3'h0, 20);
      `CHK("trigLedGreen", 8'h00, trigLedGreen)
      pulse(1);
      `CHK("readoutCode", 8'h04, readoutCode)
      for (int i = 0; i < 8 && beep !== 1'b1; i++) tick(1);
      `CHK("beep", 1'b1, beep)
      if (beep !== 1'b1) final_report();
      opMsgCode = 8'h27;
      pulse(2);
      `CHK("readoutCode", 8'h27, readoutCode)
      waitMsg(3'h0, 25);
      pulse(0);
      tick(2);
      `CHK("readoutMsg", 3'h0, readoutMsg)
   endtask
   task automatic sc_fail(input logic [15:0] e);
      lat = e[12] ? 3'h1 : 3'h6;
      boot(1'b0, 1'b0, 8'h01 << e[14:12], e[9:8]);
      waitMsg(3'h3, 300);
      `CHK("readoutCode", e[7:0], readoutCode)
      `CHK("trigLedRed", 8'h01 << e[14:12], trigLedRed)
      `CHK("trigLedGreen", (8'h01 << e[14:12]) - 8'h01, trigLedGreen)
      tick(12);
      `CHK("readoutMsg", 3'h3, readoutMsg)
      anyKeyPin = 1'b1;
      tick(2);
      anyKeyPin = 1'b0;
      waitMsg((e[14:12] == 3'h7) ? 3'h2 : 3'h1, 10);
      `CHK("trigLedRed", 8'h00, trigLedRed)
      if (e[14:12] != 3'h7) begin
         for (int i = 0; i < 10 && testStart !== 1'b1; i++) tick(1);
         `CHK("testStart", 1'b1, testStart)
         if (testStart !== 1'b1) final_report();
         `CHK("testSel", e[14:12] + 3'h1, testSel)
      end
   endtask
   task automatic sc_backup_mute();
      savedSettings = 24'hA5C3B1;
      boot(1'b1, 1'b1, 8'h00, 2'h0);
      pulse(1);
      tick(1);
      `CHK("readoutMsg", 3'h1, readoutMsg)
      waitMsg(3'h2, 400);
      waitMsg(3'h0, 20);
      pulse(0);
      `CHK("readoutCode", 8'h03, readoutCode)
      tick(8);
      `CHK("readoutMsg", 3'h4, readoutMsg)
      `CHK("beep", 1'b0, beep)
   endtask
   initial begin
      sc_pass_idle();
      foreach (tbl[i]) sc_fail(tbl[i]);
      sc_backup_mute();
      final_report();
   end
endmodule
